/* File: include/pcd_defs.svh */
`ifndef PCD_DEFS_SVH
`define PCD_DEFS_SVH
// Contract
// - Software enables DMA on one socket only
// - DMA only on 5V or externally sensed socket
// - D4 selects 8-bit or 16-bit transfers
// - Socket set to I/O card before DMA
// - D0 enables DMA; else pins normal
// - D[6:5] picks card request source pin
// - REG is DACK: high in DMA cycles
// - Card acknowledge needs DACK plus I/O command
// - Card ignores address lines during DMA
// - Card request raises host DMA request
// - Host acknowledge drives DACK high
// - IOWR for DMA read, IORD for write
// - D[2:1]=00 puts TC on WE/OE
// - Card TC lasts one bus clock
// - TC never outlasts the I/O command
// - Request on B GPIO, TC from A GPIO
// - Ack from B sense1, or IRQ7 under PnP; code takes IRQ7 only with extModeA7, else no ack pin

// Device configuration register and its fields
`define PCD_CFG_OFS        8'h3E
`define PCD_CFG_RST        8'h00
`define PCD_CFG_EN         0
`define PCD_CFG_STEER_LO   1
`define PCD_CFG_STEER_HI   2
`define PCD_CFG_WIDE       4
`define PCD_CFG_SRC_LO     5
`define PCD_CFG_SRC_HI     6
`define PCD_SRC_IOIS16     2'h0
`define PCD_SRC_SPKR       2'h1
`define PCD_SRC_INPACK     2'h2
`define PCD_STEER_DEFAULT  2'h0
`define PCD_STEER_OE       2'h1
`define PCD_STEER_WE       2'h2

// Controller registers on the AXI4-Lite side
`define PCD_AXI_CTRL_OFS   4'h0
`define PCD_AXI_CFG_OFS    4'h4
`define PCD_AXI_STAT_OFS   4'h8
`define PCD_CTRL_IOCARD    0
`define PCD_CTRL_PNP       1
`define PCD_CTRL_EXTA7     2
`define PCD_CTRL_VOLTOK    3
`define PCD_CTRL_OTHERDMA  4
`define PCD_CTRL_RST       5'h00
`define PCD_RESP_OKAY      2'h0
`define PCD_RESP_SLVERR    2'h2
`endif

/* File: include/pcd_link_if.sv */
`timescale 1ns/1ps
interface pcd_link_if;
	// Register port of the device
	logic             cfgWe;
	logic [7:0]       cfgAddr;
	logic [7:0]       cfgWdata;
	logic [7:0]       cfgRdata;
	logic             pnpEnable;
	logic             extModeA7;
	// Host handshake pins
	logic             bGpioOut;
	logic             bGpioNormal;
	logic             aGpioIn;
	logic             socketBVoltSense1N;
	logic             irq7In;
	logic             isaIorN;
	logic             isaIowN;
	// Card pins
	logic             cardIois16N;
	logic             cardSpkrN;
	logic             cardInpackN;
	logic             cardRegN;
	logic             cardIordN;
	logic             cardIowrN;
	logic             cardWeN;
	logic             cardOeN;
	logic             cardCe2N;
	// Normal (non-DMA) values of the shared card pins
	logic             regNormalN;
	logic             iordNormalN;
	logic             iowrNormalN;
	logic             weNormalN;
	logic             oeNormalN;
	logic             ce2NormalN;

	modport dev (
		input  cfgWe, cfgAddr, cfgWdata, pnpEnable, extModeA7,
		input  bGpioNormal, aGpioIn, socketBVoltSense1N, irq7In, isaIorN, isaIowN,
		input  cardIois16N, cardSpkrN, cardInpackN,
		input  regNormalN, iordNormalN, iowrNormalN, weNormalN, oeNormalN, ce2NormalN,
		output cfgRdata, bGpioOut, cardRegN, cardIordN, cardIowrN, cardWeN, cardOeN, cardCe2N
	);
	modport host (
		output cfgWe, cfgAddr, cfgWdata, pnpEnable, extModeA7,
		output bGpioNormal, aGpioIn, socketBVoltSense1N, irq7In, isaIorN, isaIowN,
		output cardIois16N, cardSpkrN, cardInpackN,
		output regNormalN, iordNormalN, iowrNormalN, weNormalN, oeNormalN, ce2NormalN,
		input  cfgRdata, bGpioOut, cardRegN, cardIordN, cardIowrN, cardWeN, cardOeN, cardCe2N
	);
endinterface

/* File: include/pcd_pkg.sv */
package pcd_pkg;
	typedef logic [7:0] pcd_byte_t;
	typedef logic [1:0] pcd_sel_t;

	// Whole state of the device end
	typedef struct packed {
		pcd_byte_t cfg;
		logic      dack;
		logic      host_dma_request;
		logic      tcPulse;
		logic      tcSeen;
	} pcd_dev_state_t;

	// Whole state of the controller end
	typedef struct packed {
		logic        awHeld;
		logic [3:0]  awAddr;
		logic        wHeld;
		logic [31:0] wData;
		logic        wStrb0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [4:0]  ctrl;
		logic        cfgWe;
		pcd_byte_t   cfgWdata;
	} pcd_host_state_t;
endpackage

/* File: test/pcd_link_assertions.sv */
`timescale 1ns/1ps
module pcd_link_assertions (
	input wire logic       sys_clk,            // Clock
	input wire logic       arst_n,             // Reset
	input wire logic [7:0] cfgRdata,           // Device config
	input wire logic       pnpEnable,          // PnP on
	input wire logic       extModeA7,          // Ack on IRQ7
	input wire logic       bGpioOut,           // Request pin
	input wire logic       bGpioNormal,        // Pin outside DMA
	input wire logic       aGpioIn,            // Host TC
	input wire logic       socketBVoltSense1N, // Ack pin
	input wire logic       irq7In,             // Alt ack pin
	input wire logic       isaIorN,            // Read command
	input wire logic       isaIowN,            // Write command
	input wire logic       cardIois16N,        // Source 0
	input wire logic       cardSpkrN,          // Source 1
	input wire logic       cardInpackN,        // Source 2
	input wire logic       cardRegN,           // DACK
	input wire logic       regNormalN,         // REG outside DMA
	input wire logic       cardIordN,          // Card read
	input wire logic       cardIowrN,          // Card write
	input wire logic       cardWeN,            // WE
	input wire logic       cardOeN,            // OE
	input wire logic       cardCe2N            // Width strobe
);
	// Decoded view of the link; cfgAddr is fixed, so cfgRdata is the register
	wire       on    = cfgRdata[0];
	wire [1:0] src   = cfgRdata[6:5];
	wire [1:0] steer = cfgRdata[2:1];
	wire       reqN  = src == 2'h0 ? cardIois16N : src == 2'h1 ? cardSpkrN : src == 2'h2 ? cardInpackN : 1'b1;
	wire       ackN  = pnpEnable ? (!extModeA7 | irq7In) : socketBVoltSense1N;
	wire       cmd   = !isaIorN | !isaIowN;
	wire       dack  = on & cardRegN;
	wire       tcOn  = dack & (!cardWeN | !cardOeN);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	a_normal_pins: assert property (!on |-> bGpioOut == bGpioNormal && cardRegN == regNormalN)
		else $error("pins not normal with DMA off");
	a_req_to_drq: assert property (on && !reqN |=> bGpioOut || !on)
		else $error("request not passed up");
	a_ack_to_dack: assert property (on && !ackN |=> cardRegN || !on)
		else $error("acknowledge did not raise DACK");
	a_cmd_pass: assert property (dack |-> cardIowrN == isaIowN && cardIordN == isaIorN)
		else $error("command not passed to card");
	a_width_ce2: assert property (dack && cmd |-> cardCe2N == !cfgRdata[4])
		else $error("transfer width wrong");
	a_tc_steer: assert property (tcOn && steer == 2'h0 |-> (!isaIowN ? !cardWeN && cardOeN : !cardOeN && cardWeN))
		else $error("TC on wrong strobe");
	a_tc_follows: assert property ($rose(aGpioIn) && dack && cmd && steer != 2'h3 ##1 dack && cmd |-> tcOn)
		else $error("TC not presented");
	a_tc_one_clk: assert property (tcOn |=> !tcOn)
		else $error("TC longer than one clock");
	a_tc_in_cmd: assert property (tcOn |-> cmd)
		else $error("TC outside command");
	a_dack_release: assert property (dack && reqN && !cmd && ackN |=> !cardRegN || !on)
		else $error("DACK not released");
	a_drq_release: assert property (on && reqN && !(dack && cmd) |=> !bGpioOut || !on)
		else $error("request not released");

	c_tc: cover property (tcOn);
	c_dma_read: cover property (dack && !isaIowN);
	c_pnp_ack: cover property (dack && pnpEnable);
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
	logic        sys_clk, arst_n;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        isaDackN, isaTc, isaIorN, isaIowN, gpioBNormal;
	logic [2:0]  reqN;
	logic [5:0]  normN;
	logic        isaDrq, cardDmaAck, cardAddrValid, dmaEnabled, dackActive, tcStrobe;
	int          mismatches, n_compared;
	logic [8:0]  cases [5] = '{9'h111, 9'h021, 9'h143, 9'h055, 9'h107};
	logic [7:0]  gates [3] = '{8'h08, 8'h01, 8'h19};

	pcd_link_if link();
	pcd_dev_end i_pcd_dev_end (.sys_clk, .arst_n, .link(link), .dmaEnabled, .dackActive, .tcStrobe);
	pcd_host_end i_pcd_host_end (.sys_clk, .arst_n, .link(link),
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.isaDackN, .isaTc, .isaIorN, .isaIowN, .gpioBNormal, .cardReqLinesN(reqN), .cardNormalN(normN),
		.isaDrq, .cardDmaAck, .cardAddrValid);
	pcd_link_assertions i_pcd_link_assertions (.sys_clk, .arst_n, .cfgRdata(link.cfgRdata),
		.pnpEnable(link.pnpEnable), .extModeA7(link.extModeA7), .bGpioOut(link.bGpioOut),
		.bGpioNormal(link.bGpioNormal), .aGpioIn(link.aGpioIn), .socketBVoltSense1N(link.socketBVoltSense1N),
		.irq7In(link.irq7In), .isaIorN(link.isaIorN), .isaIowN(link.isaIowN), .cardIois16N(link.cardIois16N),
		.cardSpkrN(link.cardSpkrN), .cardInpackN(link.cardInpackN), .cardRegN(link.cardRegN),
		.regNormalN(link.regNormalN), .cardIordN(link.cardIordN), .cardIowrN(link.cardIowrN),
		.cardWeN(link.cardWeN), .cardOeN(link.cardOeN), .cardCe2N(link.cardCe2N));

	// Free-running bus clock, 40 ns
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Hang guard at 2500 cycles, far beyond the under two hundred cycles the run needs
	initial begin
		#100000;
		mismatches++;
		results();
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask

	// Ready is sampled at the falling edge; it only moves on rising edges
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rsp);
		logic aOk, wOk, b;
		logic [1:0] r;
		b = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(negedge sys_clk);
			aOk = s_axi_awvalid && s_axi_awready;
			wOk = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge sys_clk);
			if (aOk) s_axi_awvalid <= 1'b0;
			if (wOk) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk(r, rsp);
	endtask

	task automatic axi_rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] rsp);
		logic ok, v;
		logic [31:0] d;
		logic [1:0] r;
		v = 1'b0;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!v) begin
			@(negedge sys_clk);
			ok = s_axi_arvalid && s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge sys_clk);
			if (ok) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(d, exp);
		chk(r, rsp);
	endtask

	// One full transfer: request, acknowledge, command with TC, release
	task automatic dma(input logic [7:0] cfg, input logic rd);
		logic [1:0] st;
		logic [2:0] tcExp;
		st = cfg[2:1];
		tcExp = {st != 2'h3, !(st == 2'h0 ? rd : st == 2'h2), !(st == 2'h0 ? !rd : st == 2'h1)};
		axi_wr(4'h4, {24'h0, cfg}, 2'h0);
		@(posedge sys_clk);
		reqN[cfg[6:5]] <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk({isaDrq, dackActive}, 2'b10);
		@(posedge sys_clk);
		isaDackN <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk({link.cardRegN, dackActive, cardDmaAck}, 3'b110);
		@(posedge sys_clk);
		isaIowN <= !rd;
		isaIorN <= rd;
		isaTc <= 1'b1;
		@(negedge sys_clk);
		chk({link.cardIowrN, link.cardIordN, cardDmaAck, cardAddrValid}, {!rd, rd, 2'b10});
		chk(link.cardCe2N, !cfg[4]);
		@(posedge sys_clk);
		isaTc <= 1'b0;
		@(negedge sys_clk);
		chk({tcStrobe, link.cardWeN, link.cardOeN}, tcExp);
		@(posedge sys_clk);
		isaIowN <= 1'b1;
		isaIorN <= 1'b1;
		isaDackN <= 1'b1;
		reqN <= 3'h7;
		@(negedge sys_clk);
		chk({tcStrobe, link.cardWeN, link.cardOeN}, 3'h3);
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk({dackActive, isaDrq}, 2'h0);
	endtask

	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{isaDackN, isaTc, isaIorN, isaIowN, gpioBNormal} = 5'h16;
		reqN = 3'h7;
		normN = 6'h3F;
		arst_n = 1'b0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		axi_rd(4'h0, 32'h0, 2'h0);
		axi_rd(4'h4, 32'h0, 2'h0);
		chk(dmaEnabled, 1'b0);
		axi_rd(4'hC, 32'h0, 2'h2);
		axi_wr(4'hC, 32'h1, 2'h2);
		// Enable is refused unless socket type, voltage and exclusivity are right
		foreach (gates[i]) begin
			axi_wr(4'h0, {24'h0, gates[i]}, 2'h0);
			axi_wr(4'h4, 32'h1, 2'h0);
			axi_rd(4'h4, 32'h0, 2'h0);
		end
		axi_wr(4'h0, 32'h9, 2'h0);
		foreach (cases[i]) dma(cases[i][7:0], cases[i][8]);
		axi_wr(4'h0, 32'hF, 2'h0);
		dma(8'h11, 1'b0);
		// PnP without the IRQ7 option leaves no acknowledge pin; source code 11 leaves no request pin
		axi_wr(4'h0, 32'hB, 2'h0);
		axi_wr(4'h4, 32'h61, 2'h0);
		reqN <= 3'h0;
		isaDackN <= 1'b0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({isaDrq, dackActive, link.cardRegN}, 3'h0);
		@(posedge sys_clk);
		reqN <= 3'h7;
		isaDackN <= 1'b1;
		axi_wr(4'h4, 32'h0, 2'h0);
		gpioBNormal <= 1'b1;
		normN <= 6'h3E;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk({link.bGpioOut, link.cardRegN, isaDrq}, 3'h4);
		results();
	end
endmodule

/* File: verilog/pcd_dev_end.sv */
`timescale 1ns/1ps
`include "pcd_defs.svh"
module pcd_dev_end (
	input  wire logic  sys_clk,     // ISA bus clock
	input  wire logic  arst_n,      // Async reset, active low
	pcd_link_if.dev    link,        // Pins toward host and card
	output logic       dmaEnabled,  // DMA mode on
	output logic       dackActive,  // DACK held high
	output logic       tcStrobe     // Card TC in this cycle
);
	pcd_pkg::pcd_dev_state_t s;
	pcd_pkg::pcd_dev_state_t n;

	logic              dmaEn;
	pcd_pkg::pcd_sel_t srcSel;
	pcd_pkg::pcd_sel_t steerSel;
	logic              wide;
	logic              cardReqN;
	logic              cardReq;
	logic              hostAckN;
	logic              hostAck;
	logic              hostTc;
	logic              cmdRd;
	logic              cmdWr;
	logic              cmdActive;
	logic              dmaReadCyc;
	logic              dmaWriteCyc;
	logic              tcLive;
	logic              tcOnWe;
	logic              tcOnOe;

	// Where the card TC goes for the present cycle direction
	function automatic logic tcRoute(input pcd_pkg::pcd_sel_t steer, input logic readCyc,
		input logic toWe);
		logic r;
		r = 1'b0;
		unique case (steer)
			`PCD_STEER_DEFAULT: r = toWe ? readCyc : !readCyc;
			`PCD_STEER_OE:      r = !toWe;
			`PCD_STEER_WE:      r = toWe;
			default:            r = 1'b0;                       // Steering off
		endcase
		return r;
	endfunction

	// Field decode of the configuration register
	assign dmaEn    = s.cfg[`PCD_CFG_EN];
	assign srcSel   = s.cfg[`PCD_CFG_SRC_HI:`PCD_CFG_SRC_LO];
	assign steerSel = s.cfg[`PCD_CFG_STEER_HI:`PCD_CFG_STEER_LO];
	assign wide     = s.cfg[`PCD_CFG_WIDE];

	// Card request source; code 11 selects no pin at all
	always_comb begin
		unique case (srcSel)
			`PCD_SRC_IOIS16: cardReqN = link.cardIois16N;
			`PCD_SRC_SPKR:   cardReqN = link.cardSpkrN;
			`PCD_SRC_INPACK: cardReqN = link.cardInpackN;
			default:         cardReqN = 1'b1;
		endcase
	end
	assign cardReq = dmaEn && !cardReqN;

	// Host acknowledge pin depends on plug-and-play use
	always_comb begin
		if (!link.pnpEnable) begin
			hostAckN = link.socketBVoltSense1N;
		end else if (link.extModeA7) begin
			hostAckN = link.irq7In;
		end else begin
			hostAckN = 1'b1;                     // No acknowledge pin left
		end
	end
	assign hostAck = dmaEn && !hostAckN;
	assign hostTc  = dmaEn && link.aGpioIn;

	// Host I/O commands seen while DACK is up
	assign cmdRd       = !link.isaIorN;
	assign cmdWr       = !link.isaIowN;
	assign cmdActive   = s.dack && (cmdRd || cmdWr);
	assign dmaReadCyc  = s.dack && cmdWr;  // Memory to card: card is written
	assign dmaWriteCyc = s.dack && cmdRd;  // Card to memory: card is read

	// TC gated by the live command, so it cannot outlast the strobe
	assign tcLive = s.tcPulse && cmdActive;
	assign tcOnWe = tcLive && tcRoute(steerSel, dmaReadCyc, 1'b1);
	assign tcOnOe = tcLive && tcRoute(steerSel, dmaReadCyc, 1'b0);

	// Next-state logic
	always_comb begin
		n = s;
		n.cfg = s.cfg;
		if (link.cfgWe && link.cfgAddr == `PCD_CFG_OFS) begin
			n.cfg = link.cfgWdata;
		end
		// DACK rises on acknowledge, falls once acknowledge, request and command are gone
		if (!dmaEn) begin
			n.dack = 1'b0;
		end else if (hostAck) begin
			n.dack = 1'b1;
		end else if (!cardReq && !cmdActive) begin
			n.dack = 1'b0;
		end
		// Request kept up through the command that serves it
		n.host_dma_request = cardReq || (dmaEn && s.host_dma_request && cmdActive);
		// One clock of TC per command, in the clock after TC first meets it
		n.tcPulse = hostTc && cmdActive && !s.tcSeen;
		n.tcSeen  = cmdActive && (s.tcSeen || hostTc);
	end

	// State register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s.cfg     <= `PCD_CFG_RST;
			s.dack    <= 1'b0;
			s.host_dma_request    <= 1'b0;
			s.tcPulse <= 1'b0;
			s.tcSeen  <= 1'b0;
		end else begin
			s <= n;
		end
	end

	// Register read-back
	assign link.cfgRdata = (link.cfgAddr == `PCD_CFG_OFS) ? s.cfg : 8'h00;

	// Host request on B GPIO only in DMA mode
	assign link.bGpioOut = dmaEn ? s.host_dma_request : link.bGpioNormal;

	// REG carries DACK in DMA mode: high through the DMA cycle, low between; normal REG when DMA is off
	assign link.cardRegN = dmaEn ? s.dack : link.regNormalN;

	// Card strobes follow the host command directly, IOW to IOWR and IOR to IORD, while DACK is up
	assign link.cardIowrN = s.dack ? link.isaIowN : link.iowrNormalN;
	assign link.cardIordN = s.dack ? link.isaIorN : link.iordNormalN;

	// TC borrows WE or OE; both stay inactive otherwise during DACK
	always_comb begin
		if (tcOnWe) begin
			link.cardWeN = 1'b0;
		end else if (s.dack) begin
			link.cardWeN = 1'b1;
		end else begin
			link.cardWeN = link.weNormalN;
		end
		if (tcOnOe) begin
			link.cardOeN = 1'b0;
		end else if (s.dack) begin
			link.cardOeN = 1'b1;
		end else begin
			link.cardOeN = link.oeNormalN;
		end
	end

	// During DACK, upper byte lane opened only for 16-bit commands; normal CE2 outside DACK
	always_comb begin
		if (cmdActive) begin
			link.cardCe2N = !wide;
		end else if (s.dack) begin
			link.cardCe2N = 1'b1;
		end else begin
			link.cardCe2N = link.ce2NormalN;
		end
	end

	// Status toward the user side
	assign dmaEnabled = dmaEn;
	assign dackActive = s.dack;
	// Reported only when TC really reaches a card strobe; steering code 11 sends it nowhere
	assign tcStrobe   = tcOnWe || tcOnOe;
endmodule

/* File: verilog/pcd_host_end.sv */
`timescale 1ns/1ps
`include "pcd_defs.svh"
module pcd_host_end (
	input  wire logic         sys_clk,        // ISA bus clock
	input  wire logic         arst_n,         // Async reset, active low
	pcd_link_if.host          link,           // Pins toward the device
	input  wire logic [3:0]   s_axi_awaddr,   // Write address
	input  wire logic         s_axi_awvalid,  // Write address valid
	output logic              s_axi_awready,  // Write address ready
	input  wire logic [31:0]  s_axi_wdata,    // Write data
	input  wire logic [3:0]   s_axi_wstrb,    // Byte enables
	input  wire logic         s_axi_wvalid,   // Write data valid
	output logic              s_axi_wready,   // Write data ready
	output logic [1:0]        s_axi_bresp,    // Write response
	output logic              s_axi_bvalid,   // Write response valid
	input  wire logic         s_axi_bready,   // Write response ready
	input  wire logic [3:0]   s_axi_araddr,   // Read address
	input  wire logic         s_axi_arvalid,  // Read address valid
	output logic              s_axi_arready,  // Read address ready
	output logic [31:0]       s_axi_rdata,    // Read data
	output logic [1:0]        s_axi_rresp,    // Read response
	output logic              s_axi_rvalid,   // Read data valid
	input  wire logic         s_axi_rready,   // Read data ready
	input  wire logic         isaDackN,       // Core-logic DMA acknowledge
	input  wire logic         isaTc,          // Core-logic terminal count
	input  wire logic         isaIorN,        // ISA I/O read command
	input  wire logic         isaIowN,        // ISA I/O write command
	input  wire logic         gpioBNormal,    // B GPIO value outside DMA
	input  wire logic [2:0]   cardReqLinesN,  // IOIS16, SPKR, INPACK pins
	input  wire logic [5:0]   cardNormalN,    // REG,IORD,IOWR,WE,OE,CE2 normal
	output logic              isaDrq,         // Request to core logic
	output logic              cardDmaAck,     // Valid acknowledge at card
	output logic              cardAddrValid   // Card may decode address
);
	pcd_pkg::pcd_host_state_t s;
	pcd_pkg::pcd_host_state_t n;
	logic                     dmaOn;
	logic                     enableAllowed;

	// Shadow of device enable, read back from the device itself
	assign dmaOn = link.cfgRdata[`PCD_CFG_EN];
	// Enable only for a sole, I/O-type, suitably sensed socket
	assign enableAllowed = s.ctrl[`PCD_CTRL_IOCARD]
		&& s.ctrl[`PCD_CTRL_VOLTOK]
		&& !s.ctrl[`PCD_CTRL_OTHERDMA];

	// Bus handshakes; writes wait until both halves are held
	assign s_axi_awready = !s.awHeld && !s.bvalid;
	assign s_axi_wready  = !s.wHeld && !s.bvalid;
	assign s_axi_arready = !s.rvalid;

	// Next-state logic
	always_comb begin
		n = s;
		n.cfgWe = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			n.awHeld = 1'b1;
			n.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.wHeld  = 1'b1;
			n.wData  = s_axi_wdata;
			n.wStrb0 = s_axi_wstrb[0];
		end
		if (s.awHeld && s.wHeld) begin
			n.awHeld = 1'b0;
			n.wHeld  = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = `PCD_RESP_OKAY;
			unique case (s.awAddr)
				`PCD_AXI_CTRL_OFS: begin
					if (s.wStrb0) begin
						n.ctrl = s.wData[4:0];
					end
				end
				`PCD_AXI_CFG_OFS: begin
					if (s.wStrb0) begin
						n.cfgWe    = 1'b1;
						n.cfgWdata = s.wData[7:0];
						n.cfgWdata[`PCD_CFG_EN] = s.wData[`PCD_CFG_EN] && enableAllowed;
					end
				end
				`PCD_AXI_STAT_OFS: n.bresp = `PCD_RESP_OKAY;  // Read-only, write ignored
				default:           n.bresp = `PCD_RESP_SLVERR;
			endcase
		end else if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			n.rvalid = 1'b1;
			n.rresp  = `PCD_RESP_OKAY;
			unique case (s_axi_araddr)
				`PCD_AXI_CTRL_OFS: n.rdata = {27'h0000000, s.ctrl};
				`PCD_AXI_CFG_OFS:  n.rdata = {24'h000000, link.cfgRdata};
				`PCD_AXI_STAT_OFS: n.rdata = {29'h00000000, cardDmaAck, link.cardRegN, isaDrq};
				default: begin
					n.rdata = 32'h00000000;
					n.rresp = `PCD_RESP_SLVERR;
				end
			endcase
		end else if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.ctrl <= `PCD_CTRL_RST;
		end else begin
			s <= n;
		end
	end

	// Bus outputs from flops
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp  = s.bresp;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata  = s.rdata;
	assign s_axi_rresp  = s.rresp;

	// Device register port; address is fixed at the one register
	assign link.cfgWe     = s.cfgWe;
	assign link.cfgAddr   = `PCD_CFG_OFS;
	assign link.cfgWdata  = s.cfgWdata;
	assign link.pnpEnable = s.ctrl[`PCD_CTRL_PNP];
	assign link.extModeA7 = s.ctrl[`PCD_CTRL_EXTA7];

	// Acknowledge goes on the pin the device listens to in this mode
	assign link.socketBVoltSense1N = s.ctrl[`PCD_CTRL_PNP] ? 1'b1 : isaDackN;
	assign link.irq7In             = s.ctrl[`PCD_CTRL_PNP] ? isaDackN : 1'b1;
	assign link.aGpioIn            = isaTc;
	assign link.isaIorN            = isaIorN;
	assign link.isaIowN            = isaIowN;
	assign link.bGpioNormal        = gpioBNormal;
	assign isaDrq                  = dmaOn && link.bGpioOut;

	// Card side pins
	assign link.cardIois16N = cardReqLinesN[0];
	assign link.cardSpkrN   = cardReqLinesN[1];
	assign link.cardInpackN = cardReqLinesN[2];
	assign link.regNormalN  = cardNormalN[0];
	assign link.iordNormalN = cardNormalN[1];
	assign link.iowrNormalN = cardNormalN[2];
	assign link.weNormalN   = cardNormalN[3];
	assign link.oeNormalN   = cardNormalN[4];
	assign link.ce2NormalN  = cardNormalN[5];

	// High DACK alone is no acknowledge; a command must be present too
	assign cardDmaAck    = dmaOn && link.cardRegN && (!link.cardIordN || !link.cardIowrN);
	// Card address is meaningless while DACK is up
	assign cardAddrValid = !(dmaOn && link.cardRegN);
endmodule
